// file: logic/spibc_defines.vh
// Offsets, field positions, reset values and timing counts of the serial port register slice
`ifndef SPIBC_DEFINES_VH
`define SPIBC_DEFINES_VH
// ==========================================
// Register offsets
`define SPIBC_OFS_CTRL      8'h00
`define SPIBC_OFS_BAUD      8'h0c
`define SPIBC_OFS_MINPL     8'h0e
`define SPIBC_OFS_ENCLR     8'h14
`define SPIBC_OFS_ENSET     8'h16
`define SPIBC_OFS_FLAGS     8'h18
`define SPIBC_OFS_FLCLR     8'h1a
// ==========================================
// Control fields
`define SPIBC_CTRL_SRATE    0
`define SPIBC_CTRL_IRSEL    1
`define SPIBC_CTRL_SOFDET   2
`define SPIBC_CTRL_MASK     3'h7
// ==========================================
// Interrupt bit layout
`define SPIBC_IRQ_ERROR     7
`define SPIBC_IRQ_RSVD      6
`define SPIBC_IRQ_BREAK     5
`define SPIBC_IRQ_CTSCHG    4
`define SPIBC_IRQ_RXSTART   3
`define SPIBC_IRQ_RXDONE    2
`define SPIBC_IRQ_TXDONE    1
`define SPIBC_IRQ_TXEMPTY   0
`define SPIBC_IRQ_MASK      8'hbf
`define SPIBC_EVT_MASK      8'hb7
// ==========================================
// Baud layout
`define SPIBC_FRAC_HI       15
`define SPIBC_FRAC_LO       13
`define SPIBC_FINT_HI       12
// ==========================================
// Reset values
`define SPIBC_RST_BAUD      16'h0000
`define SPIBC_RST_MINPL     8'h00
`define SPIBC_RST_EN        8'h00
`define SPIBC_RST_CTRL      3'h0
// ==========================================
// Serial engine clock: period in ns and divider count at 4 ns
`define SPIBC_SYS_PER_NS    4
`define SPIBC_SERIAL_ENGINE_CLOCK_PERIOD_NS     16
`define SPIBC_SE_DIV        (`SPIBC_SERIAL_ENGINE_CLOCK_PERIOD_NS / `SPIBC_SYS_PER_NS)
`define SPIBC_PLEN_MAX      9'h1ff
`endif

// file: logic/spibc_top.v
// Serial port register slice: baud, infrared pulse filter, interrupt enables and flags
//
// Functional notes
// (RULE1) Rate select clear: whole baud is integer
// (RULE2) Rate select set: three fraction, thirteen integer
// (RULE3) Infrared pulse accepted if length at least setting+1
// (RULE4) Clear register write clears enables written one
// (RULE5) Set register write sets enables written one
// (RULE6) Both enable registers read one shared state
// (RULE7) Enable layout: error7 break5 cts4 rxs3 rxc2 txc1 dre0
// (RULE8) Bit six reserved, reads zero, write zero
// (RULE9) Source interrupts only while its enable reads one
// (RULE10) Encoding select: zero plain, one infrared filtered
// (RULE11) Start seen with detect enabled sets receive start
// (RULE12) Interrupt line ORs every flag and enable pair
`timescale 1ns/1ps
`include "spibc_defines.vh"

module spibc_top (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        nrst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata_ff,
	// Serial receive line and event sources
	input  wire        rx_line,
	input  wire [7:0]  evt_in,
	// Clock generation settings
	output reg  [15:0] baud_int_ff,
	output reg  [2:0]  baud_frac_ff,
	output reg         frac_mode_ff,
	// Receiver side
	output reg         rx_data_ff,
	output reg         ir_pulse_ok_ff,
	output reg         se_tick_ff,
	// Interrupt
	output reg         irq_ff
);

	// ==========================================
	// Helpers
	function [7:0] spibc_apply;
		input [7:0] cur;
		input [7:0] bits;
		input       set;
		begin
			if (set) begin
				spibc_apply = (cur | bits) & `SPIBC_IRQ_MASK;
			end else begin
				spibc_apply = cur & ~bits;
			end
		end
	endfunction

	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	function [15:0] spibc_int_part;
		input [15:0] val;
		input        frac;
		begin
			if (frac) begin
				spibc_int_part = {3'h0, val[`SPIBC_FINT_HI:0]};
			end else begin
				spibc_int_part = val;
			end
		end
	endfunction

	function [2:0] spibc_frac_part;
		input [15:0] val;
		input        frac;
		begin
			if (frac) begin
				spibc_frac_part = val[`SPIBC_FRAC_HI:`SPIBC_FRAC_LO];
			end else begin
				// Arithmetic mode has no fraction; a zero keeps the generator sum plain
				spibc_frac_part = 3'h0;
			end
		end
	endfunction

	// ==========================================
	// State
	reg [2:0]  ctrl_ff;
	reg [15:0] baud_ff;
	reg [7:0]  minpl_ff;
	reg [7:0]  en_ff;
	reg [7:0]  flags_ff;
	reg [7:0]  div_ff;
	reg        rx_prev_ff;
	reg [8:0]  plen_ff;

	reg [2:0]  nxt_ctrl;
	reg [15:0] nxt_baud;
	reg [7:0]  nxt_minpl;
	reg [7:0]  nxt_en;
	reg [7:0]  nxt_flags;
	reg [7:0]  nxt_set;
	reg [7:0]  nxt_clr;
	reg [15:0] nxt_rdata;
	reg [8:0]  nxt_plen;
	reg        nxt_ok;

	wire       ir_mode = ctrl_ff[`SPIBC_CTRL_IRSEL];
	wire       sof_det_en = ctrl_ff[`SPIBC_CTRL_SOFDET];
	wire       start_seen = rx_prev_ff & ~rx_line;
	wire [8:0] plen_min = {1'b0, minpl_ff} + 9'h001;

	// ==========================================
	// Register writes
	always @* begin
		nxt_ctrl = ctrl_ff;
		nxt_baud = baud_ff;
		nxt_minpl = minpl_ff;
		nxt_en = en_ff;
		nxt_clr = 8'h00;
		if (reg_wr) begin
			if (hit(reg_addr, `SPIBC_OFS_CTRL)) begin
				nxt_ctrl = reg_wdata[2:0] & `SPIBC_CTRL_MASK;
			end
			if (hit(reg_addr, `SPIBC_OFS_BAUD)) begin
				nxt_baud = reg_wdata;
			end
			if (hit(reg_addr, `SPIBC_OFS_MINPL)) begin
				nxt_minpl = reg_wdata[7:0];
			end
			if (hit(reg_addr, `SPIBC_OFS_ENCLR)) begin
				nxt_en = spibc_apply(en_ff, reg_wdata[7:0], 1'b0); // RULE4
			end
			if (hit(reg_addr, `SPIBC_OFS_ENSET)) begin
				nxt_en = spibc_apply(en_ff, reg_wdata[7:0], 1'b1); // RULE5
			end
			if (hit(reg_addr, `SPIBC_OFS_FLCLR)) begin
				nxt_clr = reg_wdata[7:0];
			end
		end
	end

	// ==========================================
	// Sticky flags; a set in the clearing cycle wins
	always @* begin
		nxt_set = evt_in & `SPIBC_EVT_MASK;
		nxt_set[`SPIBC_IRQ_RXSTART] = start_seen & sof_det_en; // RULE11
		nxt_flags = ((flags_ff & ~nxt_clr) | nxt_set) & `SPIBC_IRQ_MASK;
	end

	// ==========================================
	// Read mux; enable storage shared by both views
	always @* begin
		nxt_rdata = 16'h0000;
		case (reg_addr)
			`SPIBC_OFS_CTRL: begin
				nxt_rdata = {13'h0000, ctrl_ff};
			end
			`SPIBC_OFS_BAUD: begin
				nxt_rdata = baud_ff;
			end
			`SPIBC_OFS_MINPL: begin
				nxt_rdata = {8'h00, minpl_ff};
			end
			`SPIBC_OFS_ENCLR, `SPIBC_OFS_ENSET: begin
				nxt_rdata = {8'h00, en_ff & `SPIBC_IRQ_MASK}; // RULE6 RULE7 RULE8
			end
			`SPIBC_OFS_FLAGS: begin
				nxt_rdata = {8'h00, flags_ff};
			end
			default: begin
				nxt_rdata = 16'h0000;
			end
		endcase
	end

	// ==========================================
	// Infrared pulse length filter, counted in serial engine ticks
	always @* begin
		nxt_plen = plen_ff;
		nxt_ok = 1'b0;
		if (rx_line) begin
			nxt_plen = 9'h000;
			// Judged at the rising end so a long pulse counts only once
			if (ir_mode && !rx_prev_ff && plen_ff >= plen_min) begin
				nxt_ok = 1'b1; // RULE3 RULE10
			end
		end else if (se_tick_ff && plen_ff != `SPIBC_PLEN_MAX) begin
			nxt_plen = plen_ff + 9'h001;
		end
	end

	// ==========================================
	// Configuration registers
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_ff <= `SPIBC_RST_CTRL;
			baud_ff <= `SPIBC_RST_BAUD;
			minpl_ff <= `SPIBC_RST_MINPL;
		end else begin
			ctrl_ff <= nxt_ctrl;
			baud_ff <= nxt_baud;
			minpl_ff <= nxt_minpl;
		end
	end

	// ==========================================
	// Enables and sticky flags
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_ff <= `SPIBC_RST_EN;
			flags_ff <= 8'h00;
		end else begin
			en_ff <= nxt_en;
			flags_ff <= nxt_flags;
		end
	end

	// ==========================================
	// Read port
	// Data stand one cycle only, so a stale word never looks like a fresh read
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_ff <= 16'h0000;
		end else begin
			if (reg_rd) begin
				reg_rdata_ff <= nxt_rdata;
			end else begin
				reg_rdata_ff <= 16'h0000;
			end
		end
	end

	// ==========================================
	// Serial engine tick divider
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_ff <= 8'h00;
			se_tick_ff <= 1'b0;
		end else begin
			if (div_ff == (`SPIBC_SE_DIV - 1)) begin
				div_ff <= 8'h00;
				se_tick_ff <= 1'b1;
			end else begin
				div_ff <= div_ff + 8'h01;
				se_tick_ff <= 1'b0;
			end
		end
	end

	// ==========================================
	// Receive line history and pulse counter
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			// Idle level, so no false start follows reset
			rx_prev_ff <= 1'b1;
			plen_ff <= 9'h000;
		end else begin
			rx_prev_ff <= rx_line;
			plen_ff <= nxt_plen;
		end
	end

	// ==========================================
	// Clock generation settings
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			baud_int_ff <= 16'h0000;
			baud_frac_ff <= 3'h0;
			frac_mode_ff <= 1'b0;
		end else begin
			frac_mode_ff <= nxt_ctrl[`SPIBC_CTRL_SRATE];
			baud_int_ff <= spibc_int_part(nxt_baud, nxt_ctrl[`SPIBC_CTRL_SRATE]); // RULE1 RULE2
			baud_frac_ff <= spibc_frac_part(nxt_baud, nxt_ctrl[`SPIBC_CTRL_SRATE]); // RULE2
		end
	end

	// ==========================================
	// Receiver outputs
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rx_data_ff <= 1'b1;
			ir_pulse_ok_ff <= 1'b0;
		end else begin
			// Plain mode passes the line; infrared mode leaves it idle
			rx_data_ff <= ir_mode ? 1'b1 : rx_line; // RULE10
			ir_pulse_ok_ff <= nxt_ok;
		end
	end

	// ==========================================
	// Interrupt line
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_flags & nxt_en); // RULE9 RULE12
		end
	end

endmodule // spibc_top

// file: test/spibc_props.sv
// Assertion checker for the serial port register slice
`timescale 1ns/1ps
module spibc_props (
	// Clock, reset and register port
	input wire        sys_clk,
	input wire        nrst,
	input wire [7:0]  reg_addr,
	input wire [15:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata_ff,
	input wire [7:0]  evt_in,
	// Watched outputs
	input wire [15:0] baud_int_ff,
	input wire [2:0]  baud_frac_ff,
	input wire        frac_mode_ff,
	input wire        se_tick_ff,
	input wire        irq_ff
);
	// ==========================================
	// Properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_rd(a); reg_rd && reg_addr == a; endsequence
	sequence s_wr(a, d); reg_wr && reg_addr == a && reg_wdata[7:0] == d; endsequence
	chk_rsvd_zero: assert property ((reg_rd && (reg_addr == 8'h14 || reg_addr == 8'h16))
		|=> reg_rdata_ff[15:8] == 8'h00 && !reg_rdata_ff[6]) else $error("enable read upper or bit 6 set");
	chk_set_clr_same: assert property (s_rd(8'h16) ##1 s_rd(8'h14)
		|=> reg_rdata_ff == $past(reg_rdata_ff)) else $error("enable views differ");
	chk_set_all: assert property (s_wr(8'h16, 8'hff) ##1 s_rd(8'h16) |=> reg_rdata_ff == 16'h00bf)
		else $error("set write not seen");
	chk_clr_all: assert property (s_wr(8'h14, 8'hff) ##1 s_rd(8'h16) |=> reg_rdata_ff == 16'h0000)
		else $error("clear write not seen");
	chk_irq_masked: assert property (s_wr(8'h14, 8'hff) ##1 !reg_wr |=> !irq_ff)
		else $error("interrupt while disabled");
	chk_irq_event: assert property ((reg_wr && reg_addr == 8'h16 && reg_wdata[7]) ##1 evt_in[7]
		|-> ##[1:2] irq_ff) else $error("enabled event gave no interrupt");
	chk_baud_arith: assert property ((reg_wr && reg_addr == 8'h0c && !frac_mode_ff)
		|=> baud_int_ff == $past(reg_wdata) && baud_frac_ff == 3'h0) else $error("integer baud wrong");
	chk_baud_frac: assert property ((reg_wr && reg_addr == 8'h0c && frac_mode_ff)
		|=> baud_int_ff[12:0] == $past(reg_wdata[12:0]) && baud_frac_ff == $past(reg_wdata[15:13]))
		else $error("fractional baud wrong");
	chk_mode_copy: assert property ((reg_wr && reg_addr == 8'h00) |=> frac_mode_ff == $past(reg_wdata[0]))
		else $error("sample rate copy wrong");
	// Engine period fixes the pulse filter unit
	chk_tick_gap: assert property (se_tick_ff |=> !se_tick_ff [*3] ##1 se_tick_ff)
		else $error("engine tick spacing wrong");
endmodule // spibc_props

// file: test/testbench.sv
// Self-checking bench for the serial port register slice
`timescale 1ns/1ps
module testbench;
	reg         sys_clk, nrst, reg_wr, reg_rd, rx_line;
	reg  [7:0]  reg_addr, evt_in;
	reg  [15:0] reg_wdata, rd_exp, exp_hold;
	wire [15:0] reg_rdata_ff, baud_int_ff;
	wire [2:0]  baud_frac_ff;
	wire        frac_mode_ff, rx_data_ff, ir_pulse_ok_ff, se_tick_ff, irq_ff;
	integer     err_count = 0, n_checks = 0, ir_cnt = 0;
	spibc_top dut (.*);
	// ==========================================
	// Tasks
	task chk(input string n, input [15:0] e, input [15:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task op(input w, input r, input [7:0] a, input [15:0] d);
		@(posedge sys_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
	endtask
	task wr(input [7:0] a, input [15:0] d); op(1'b1, 1'b0, a, d); endtask
	// Expected value goes by NBA so a back-to-back read cannot overwrite it early
	task rd(input [7:0] a, input [15:0] e); op(1'b0, 1'b1, a, 16'h0); rd_exp <= e; endtask
	task idle(input integer n); repeat (n) op(1'b0, 1'b0, 8'h00, 16'h0); endtask
	task pulse_rx(input integer n); idle(1); rx_line <= 1'b0; idle(n); rx_line <= 1'b1; idle(4); endtask
	task evt(input [7:0] e); idle(1); evt_in <= e; idle(1); evt_in <= 8'h00; endtask
	task wrap_up;
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge sys_clk) if (reg_rd === 1'b1) begin
		exp_hold = rd_exp;
		#1 chk("rdata", exp_hold, reg_rdata_ff);
	end
	always @(posedge sys_clk) if (ir_pulse_ok_ff === 1'b1) ir_cnt++;
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		#200000 err_count++;
		wrap_up;
	end
	// ==========================================
	// Sequence
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata, evt_in, rd_exp} = 0;
		rx_line = 1'b1;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(8'h0e, 16'h0);
		rd(8'h14, 16'h0);
		rd(8'h16, 16'h0);
		rd(8'h0c, 16'h0);
		rd(8'h40, 16'h0);
		wr(8'h0e, 16'h00a5); rd(8'h0e, 16'h00a5);
		wr(8'h16, 16'h00ff); rd(8'h16, 16'h00bf);
		rd(8'h14, 16'h00bf);
		wr(8'h14, 16'h0081); rd(8'h16, 16'h003e);
		wr(8'h14, 16'h00ff); rd(8'h16, 16'h0000);
		wr(8'h16, 16'h0080); evt(8'h81); idle(2);
		#1 chk("irq", 16'h1, {15'h0, irq_ff});
		wr(8'h14, 16'h00ff); idle(2);
		#1 chk("irq", 16'h0, {15'h0, irq_ff});
		rd(8'h18, 16'h0081);
		wr(8'h1a, 16'h00ff); wr(8'h16, 16'h0008); wr(8'h00, 16'h0004); pulse_rx(2);
		#1 chk("irq", 16'h1, {15'h0, irq_ff});
		rd(8'h18, 16'h0008);
		wr(8'h1a, 16'h00ff); wr(8'h14, 16'h00ff); wr(8'h00, 16'h0000); wr(8'h0c, 16'habcd); idle(1);
		#1 chk("baud", 16'habcd, baud_int_ff);
		chk("frac", 16'h0, {13'h0, baud_frac_ff});
		wr(8'h00, 16'h0001); wr(8'h0c, 16'habcd); idle(1);
		#1 chk("baud", 16'h0bcd, {3'h0, baud_int_ff[12:0]});
		chk("frac", 16'h5, {13'h0, baud_frac_ff});
		wr(8'h0e, 16'h0001); wr(8'h00, 16'h0002); pulse_rx(12); pulse_rx(2);
		chk("irpulse", 16'h1, ir_cnt[15:0]);
		wr(8'h00, 16'h0000); pulse_rx(12);
		chk("irpulse", 16'h1, ir_cnt[15:0]);
		rx_line <= 1'b0;
		idle(2);
		#1 chk("rxdata", 16'h0, {15'h0, rx_data_ff});
		wrap_up;
	end
endmodule // testbench
bind spibc_top spibc_props u_chk (.*);
